/* File: ppt_port.sv */
// printer port register block with wishbone slave, pin drivers and epp engine
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ppt_map.svh"

// How it works
// - data write stores byte, drives it unchanged on pins; reset clears it
// - data read in standard mode returns live pin levels
// - status value captured at read start, held until the read ends
// - status bit 0 sets on 10 us epp time-out; reset clears it
// - clear-select 0: writing one clears time-out flag, zero leaves it
// - clear-select 1: trailing edge of status read clears time-out flag
// - status bits one and two always read zero
// - status bit three returns error input level unchanged
// - bits four and five return online and paper-out inputs unchanged
// - status bit six returns acknowledge input level unchanged
// - status bit seven returns inverted busy input
// - reset clears control bits 0 to 5; bits 6, 7 read zero
// - control bit zero drives strobe pin inverted
// - control bit one drives autofeed pin inverted
// - control bit two drives initialise pin unchanged
// - control bit three drives select-in pin inverted
// - with enable set, acknowledge rising edge raises interrupt; else none
// - offsets 0 to 2 always decode; 3 to 7 only in epp mode
// - epp cycle lasting over 10 us is aborted and flags time-out
// - direction bit turns data pins around except in printer mode
module ppt_port #(
  parameter int ADR_W = 8
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             srst_in,
  // wishbone slave
  input  wire logic             wb_cyc_in,
  input  wire logic             wb_stb_in,
  input  wire logic             wb_we_in,
  input  wire logic [ADR_W-1:0] wb_adr_in,
  input  wire logic [3:0]       wb_sel_in,
  input  wire logic [31:0]      wb_dat_in,
  output logic      [31:0]      wb_dat_out,
  output logic                  wb_ack_out,
  // parallel data pins
  input  wire logic [7:0]       parallel_data_pins_in,
  output logic      [7:0]       parallel_data_pins_out,
  output logic                  parallel_data_pins_oe_out,
  // printer status inputs
  input  wire logic             printer_error_input_n_in,
  input  wire logic             printer_online_input_in,
  input  wire logic             paper_out_input_in,
  input  wire logic             printer_ack_input_n_in,
  input  wire logic             printer_busy_in,
  // printer control outputs
  output logic                  strobe_out_pin_n_out,
  output logic                  autofeed_out_pin_n_out,
  output logic                  printer_initialise_line_n_out,
  output logic                  select_in_out_pin_n_out,
  // interrupt request
  output logic                  port_irq_out
);
  // ****************************************************************
  // input synchronisers and edge detection
  // ****************************************************************
  logic [7:0] pins_s;
  logic [4:0] stat_raw_w;
  logic [4:0] stat_s;
  logic       err_s;
  logic       online_s;
  logic       paper_s;
  logic       ack_s;
  logic       busy_s;
  logic       ack_prev_r;
  logic       ack_rise_w;

  ppt_epp_if epp ();

  // data pins sampled for readback and epp reads
  ppt_sync #(.W(8)) u_sync_pins (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .d_in       (parallel_data_pins_in),
    .q_out      (pins_s)
  );

  // status lines; busy doubles as the peripheral wait line in epp mode
  // ack enters inverted so the cleared chain matches its idle high level: no false edge
  assign stat_raw_w = {printer_busy_in, ~printer_ack_input_n_in, paper_out_input_in,
                       printer_online_input_in, printer_error_input_n_in};
  ppt_sync #(.W(5)) u_sync_stat (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .d_in       (stat_raw_w),
    .q_out      (stat_s)
  );
  assign err_s      = stat_s[0];
  assign online_s   = stat_s[1];
  assign paper_s    = stat_s[2];
  assign ack_s      = ~stat_s[3];
  assign busy_s     = stat_s[4];
  assign ack_rise_w = ack_s & ~ack_prev_r;

  // ****************************************************************
  // registers and bus decode
  // ****************************************************************
  logic [7:0]              data_r;
  logic [`PPT_CTRL_W-1:0]  ctrl_r;
  ppt_pkg::ppt_mode_t      mode_r;
  logic                    tsel_r;
  logic                    tmo_r;
  logic                    tmo_nxt;
  logic                    ack_r;
  logic [7:0]              dat_r;
  logic                    epp_busy_r;
  logic                    irq_r;
  logic [`PPT_IDX_W-1:0]   idx_w;
  logic                    req_w;
  logic                    first_w;
  logic                    commit_w;
  logic                    wr_commit_w;
  logic                    epp_mode_w;
  logic                    epp_hit_w;
  logic                    is_stat_w;
  logic                    tmo_w1c_w;
  logic                    tmo_rdclr_w;
  logic [7:0]              stat_w;
  logic [7:0]              ctrl_rd_w;
  logic [7:0]              cfg_rd_w;
  logic [7:0]              rd_mux_w;

  // true for the epp address and data port indices
  function automatic logic is_epp_idx(input logic [`PPT_IDX_W-1:0] i);
    return (i >= `PPT_IDX_EPP_ADDR) && (i <= `PPT_IDX_EPP_D3);
  endfunction

  // request phases: first cycle, and the edge the master samples ack
  assign idx_w       = wb_adr_in[`PPT_IDX_LSB +: `PPT_IDX_W];
  assign req_w       = wb_cyc_in & wb_stb_in;
  assign first_w     = req_w & ~ack_r & ~epp_busy_r;
  assign commit_w    = req_w & ack_r;
  assign wr_commit_w = commit_w & wb_we_in & wb_sel_in[0];
  assign epp_mode_w  = mode_r == ppt_pkg::PPT_MODE_EPP;
  assign epp_hit_w   = is_epp_idx(idx_w) & epp_mode_w;
  assign is_stat_w   = idx_w == `PPT_IDX_STATUS;

  // status word assembled from synchronised pins
  always_comb
  begin
    stat_w                   = 8'h00;
    stat_w[`PPT_STAT_TMO]    = tmo_r & epp_mode_w;
    stat_w[`PPT_STAT_ERR]    = err_s;
    stat_w[`PPT_STAT_ONLINE] = online_s;
    stat_w[`PPT_STAT_PAPER]  = paper_s;
    stat_w[`PPT_STAT_ACK]    = ack_s;
    stat_w[`PPT_STAT_READY]  = ~busy_s;
  end

  // readback of control and configuration; unused high bits stay low
  assign ctrl_rd_w = {2'b00, ctrl_r};
  always_comb
  begin
    cfg_rd_w                                        = 8'h00;
    cfg_rd_w[`PPT_CFG_MODE_MSB:`PPT_CFG_MODE_LSB]   = mode_r;
    cfg_rd_w[`PPT_CFG_TSEL]                         = tsel_r;
  end

  // read selection; unmapped and gated epp offsets read zero
  assign rd_mux_w = (idx_w == `PPT_IDX_DATA) ? pins_s :
                    is_stat_w                ? stat_w :
                    (idx_w == `PPT_IDX_CTRL) ? ctrl_rd_w :
                    (idx_w == `PPT_IDX_CFG)  ? cfg_rd_w : 8'h00;

  // time-out flag: set wins over either way of clearing it
  assign tmo_w1c_w   = wr_commit_w & is_stat_w & ~tsel_r & wb_dat_in[`PPT_STAT_TMO];
  assign tmo_rdclr_w = commit_w & ~wb_we_in & is_stat_w & tsel_r;
  assign tmo_nxt     = epp.tmo | (tmo_r & ~(tmo_w1c_w | tmo_rdclr_w));

  assign wb_ack_out = ack_r;
  assign wb_dat_out = {24'h000000, dat_r};

  // bus handshake; a register read value is frozen at the first cycle, an epp read value when the engine is done, until ack
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      ack_r      <= 1'b0;
      dat_r      <= 8'h00;
      epp_busy_r <= 1'b0;
    end
    else
    begin
      ack_r <= 1'b0;
      if (first_w && epp_hit_w)
        epp_busy_r <= 1'b1;
      else if (first_w)
      begin
        ack_r <= 1'b1;
        dat_r <= rd_mux_w;
      end
      else if (epp_busy_r && epp.done)
      begin
        epp_busy_r <= 1'b0;
        ack_r      <= 1'b1;
        dat_r      <= epp.rdata;
      end
    end
  end

  // software registers; writes land on the edge the master takes ack
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      data_r <= `PPT_DATA_RST;
      ctrl_r <= `PPT_CTRL_RST;
      mode_r <= ppt_pkg::PPT_MODE_PRINTER;
      tsel_r <= 1'b0;
      tmo_r  <= 1'b0;
    end
    else
    begin
      tmo_r <= tmo_nxt;
      if (wr_commit_w && idx_w == `PPT_IDX_DATA)
        data_r <= wb_dat_in[7:0];
      if (wr_commit_w && idx_w == `PPT_IDX_CTRL)
        ctrl_r <= wb_dat_in[`PPT_CTRL_W-1:0];
      if (wr_commit_w && idx_w == `PPT_IDX_CFG)
      begin
        mode_r <= ppt_pkg::ppt_mode_t'(wb_dat_in[`PPT_CFG_MODE_MSB:`PPT_CFG_MODE_LSB]);
        tsel_r <= wb_dat_in[`PPT_CFG_TSEL];
      end
    end
  end

  // ****************************************************************
  // epp engine
  // ****************************************************************
  // a write with the direction bit set turns into a read, as on the real port
  assign epp.start      = first_w & epp_hit_w;
  assign epp.is_write   = wb_we_in & wb_sel_in[0] & ~ctrl_r[`PPT_CTRL_DIR];
  assign epp.is_addr    = idx_w == `PPT_IDX_EPP_ADDR;
  assign epp.start_data = wb_dat_in[7:0];
  assign epp.wait_n     = busy_s;
  assign epp.pins       = pins_s;

  ppt_epp u_epp (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .epp        (epp.eng)
  );

  // ****************************************************************
  // pin drivers and interrupt
  // ****************************************************************
  logic [7:0] pd_nxt;
  logic       pd_oe_nxt;
  logic       strobe_nxt;
  logic       autofeed_ctrl_bit_nxt;
  logic       selin_nxt;
  logic       irq_nxt;

  // epp strobes borrow the control lines only while a cycle runs
  assign pd_nxt     = epp.active ? epp.wdata : data_r;
  assign pd_oe_nxt  = (mode_r == ppt_pkg::PPT_MODE_PRINTER) ? 1'b1 :
                      epp.active ? epp.drive : ~ctrl_r[`PPT_CTRL_DIR];
  assign strobe_nxt = epp.active ? epp.write_n : ~ctrl_r[`PPT_CTRL_STROBE];
  assign autofeed_ctrl_bit_nxt = epp.active ? epp.dstb_n : ~ctrl_r[`PPT_CTRL_AUTOFEED_CTRL_BIT];
  assign selin_nxt  = epp.active ? epp.astb_n : ~ctrl_r[`PPT_CTRL_SELIN];
  assign irq_nxt    = ack_rise_w & ctrl_r[`PPT_CTRL_IEN];

  // all pin outputs registered so they change together and glitch free
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      parallel_data_pins_out        <= `PPT_DATA_RST;
      parallel_data_pins_oe_out     <= 1'b1;
      strobe_out_pin_n_out          <= 1'b1;
      autofeed_out_pin_n_out        <= 1'b1;
      printer_initialise_line_n_out <= 1'b0;
      select_in_out_pin_n_out       <= 1'b1;
      irq_r                         <= 1'b0;
      ack_prev_r                    <= 1'b1;
    end
    else
    begin
      parallel_data_pins_out        <= pd_nxt;
      parallel_data_pins_oe_out     <= pd_oe_nxt;
      strobe_out_pin_n_out          <= strobe_nxt;
      autofeed_out_pin_n_out        <= autofeed_ctrl_bit_nxt;
      printer_initialise_line_n_out <= ctrl_r[`PPT_CTRL_INIT];
      select_in_out_pin_n_out       <= selin_nxt;
      irq_r                         <= irq_nxt;
      ack_prev_r                    <= ack_s;
    end
  end
  assign port_irq_out = irq_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  sequence s_stat_read;
    first_w && !wb_we_in && is_stat_w;
  endsequence
  sequence s_data_write;
    wr_commit_w && idx_w == `PPT_IDX_DATA && !epp.active;
  endsequence
  sequence s_quiet_link;
    !epp.active ##1 !epp.active;
  endsequence

  a_data_to_pins : assert property (
    s_data_write ##1 !epp.active |=> parallel_data_pins_out == $past(wb_dat_in[7:0], 2))
    else $error("data write not driven onto pins");
  a_status_capture : assert property (
    s_stat_read |=> ack_r && dat_r[`PPT_STAT_READY] == !$past(busy_s)
      && dat_r[`PPT_STAT_ERR] == $past(err_s))
    else $error("status not captured at start of read");
  a_status_fixed_zero : assert property (
    s_stat_read |=> dat_r[2:1] == 2'b00 && dat_r[`PPT_STAT_ACK] == $past(ack_s))
    else $error("status bits one or two not zero");
  a_timeout_sets : assert property (
    epp.tmo |=> tmo_r)
    else $error("time-out flag not set");
  a_timeout_w1c : assert property (
    tmo_w1c_w && !epp.tmo |=> !tmo_r)
    else $error("write one did not clear time-out");
  a_timeout_rdclr : assert property (
    tmo_rdclr_w && !epp.tmo |=> !tmo_r)
    else $error("status read did not clear time-out");
  a_ctrl_top_zero : assert property (
    first_w && !wb_we_in && idx_w == `PPT_IDX_CTRL |=> dat_r[7:6] == 2'b00)
    else $error("control bits six or seven not zero");
  a_strobe_invert : assert property (
    s_quiet_link |-> strobe_out_pin_n_out == !$past(ctrl_r[`PPT_CTRL_STROBE]))
    else $error("strobe pin not inverse of control bit");
  a_ack_irq : assert property (
    ack_rise_w |=> port_irq_out == $past(ctrl_r[`PPT_CTRL_IEN]) ##1 !port_irq_out)
    else $error("acknowledge edge interrupt wrong");
  a_epp_gated : assert property (
    first_w && is_epp_idx(idx_w) && !epp_mode_w |=> ack_r && dat_r == 8'h00 && !epp_busy_r)
    else $error("epp offset answered outside epp mode");
  a_printer_drives : assert property (
    mode_r == ppt_pkg::PPT_MODE_PRINTER |=> parallel_data_pins_oe_out)
    else $error("data pins not driven in printer mode");
  a_ack_one_cycle : assert property (
    ack_r |=> !ack_r)
    else $error("ack held longer than one cycle");
endmodule // ppt_port

/* File: ppt_map.svh */
// register map, field positions, reset values and timing counts of the printer port
`ifndef PPT_MAP_SVH
`define PPT_MAP_SVH
// register indices; byte address on the bus is four times the index
`define PPT_IDX_W        4
`define PPT_IDX_LSB      2
`define PPT_IDX_DATA     4'h0
`define PPT_IDX_STATUS   4'h1
`define PPT_IDX_CTRL     4'h2
`define PPT_IDX_EPP_ADDR 4'h3
`define PPT_IDX_EPP_D3   4'h7
`define PPT_IDX_CFG      4'h8
// status fields
`define PPT_STAT_TMO     0
`define PPT_STAT_ERR     3
`define PPT_STAT_ONLINE  4
`define PPT_STAT_PAPER   5
`define PPT_STAT_ACK     6
`define PPT_STAT_READY   7
// control fields
`define PPT_CTRL_W       6
`define PPT_CTRL_STROBE  0
`define PPT_CTRL_AUTOFEED_CTRL_BIT  1
`define PPT_CTRL_INIT    2
`define PPT_CTRL_SELIN   3
`define PPT_CTRL_IEN     4
`define PPT_CTRL_DIR     5
`define PPT_CTRL_RST     6'h00
`define PPT_DATA_RST     8'h00
// configuration fields
`define PPT_CFG_MODE_LSB 0
`define PPT_CFG_MODE_MSB 1
`define PPT_CFG_TSEL     4
// epp watchdog: time in ns, clock period in ns, derived cycle count
`define PPT_TMO_NS       10000
`define PPT_CLK_NS       40
`define PPT_TMO_CYC      ((`PPT_TMO_NS) / (`PPT_CLK_NS))
`define PPT_TMO_CNT_W    9
`endif

/* File: ppt_pkg.sv */
// types shared by the printer port modules
package ppt_pkg;
  // port operating modes as held in the configuration register
  typedef enum logic [1:0] {PPT_MODE_PRINTER, PPT_MODE_BIDIR, PPT_MODE_EPP, PPT_MODE_SPARE} ppt_mode_t;
  // epp cycle engine states
  typedef enum logic [1:0] {EPP_IDLE, EPP_SETUP, EPP_STROBE} ppt_epp_state_t;
endpackage

/* File: ppt_epp_if.sv */
// signals between the register block and the epp cycle engine
`timescale 1ns/1ps
interface ppt_epp_if;
  logic       start;
  logic       is_write;
  logic       is_addr;
  logic [7:0] start_data;
  logic       wait_n;
  logic [7:0] pins;
  logic       active;
  logic       drive;
  logic       write_n;
  logic       dstb_n;
  logic       astb_n;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       done;
  logic       tmo;
  modport eng (input start, is_write, is_addr, start_data, wait_n, pins,
               output active, drive, write_n, dstb_n, astb_n, wdata, rdata, done, tmo);
  modport ctl (output start, is_write, is_addr, start_data, wait_n, pins,
               input active, drive, write_n, dstb_n, astb_n, wdata, rdata, done, tmo);
endinterface

/* File: ppt_sync.sv */
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module ppt_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         srst_in,
  // raw and filtered levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] agree_w;

  // bitwise agreement of the two settled stages
  assign agree_w = ~(s2_r ^ s3_r);
  assign q_out   = q_r;

  // s1 feeds only s2, so metastability never reaches logic
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end
    else
    begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= (agree_w & s3_r) | (~agree_w & q_r);
    end
  end
endmodule // ppt_sync

/* File: ppt_epp.sv */
// epp cycle engine: waits for the peripheral, strobes, and aborts on the watchdog
`timescale 1ns/1ps
`include "ppt_map.svh"
module ppt_epp (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic srst_in,
  // link to the register block
  ppt_epp_if.eng    epp
);
  ppt_pkg::ppt_epp_state_t        state_r;
  logic [`PPT_TMO_CNT_W-1:0]      cnt_r;
  logic                           expired_w;

  // watchdog runs from the start of the cycle until wait is released
  assign expired_w  = (state_r != ppt_pkg::EPP_IDLE) && (cnt_r == `PPT_TMO_CNT_W'(`PPT_TMO_CYC));
  assign epp.active = state_r != ppt_pkg::EPP_IDLE;
  assign epp.drive  = epp.active & ~epp.write_n;

  // cycle sequencer; an expired watchdog beats every other transition
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      state_r     <= ppt_pkg::EPP_IDLE;
      cnt_r       <= '0;
      epp.wdata   <= '0;
      epp.rdata   <= '0;
      epp.write_n <= 1'b1;
      epp.dstb_n  <= 1'b1;
      epp.astb_n  <= 1'b1;
      epp.done    <= 1'b0;
      epp.tmo     <= 1'b0;
    end
    else
    begin
      epp.done <= 1'b0;
      epp.tmo  <= 1'b0;
      if (expired_w)
      begin
        state_r     <= ppt_pkg::EPP_IDLE;
        epp.write_n <= 1'b1;
        epp.dstb_n  <= 1'b1;
        epp.astb_n  <= 1'b1;
        epp.rdata   <= '0;
        epp.done    <= 1'b1;
        epp.tmo     <= 1'b1;
      end
      else
      begin
        case (state_r)
          ppt_pkg::EPP_IDLE:
            if (epp.start)
            begin
              epp.wdata   <= epp.start_data;
              epp.write_n <= ~epp.is_write;
              cnt_r       <= '0;
              state_r     <= ppt_pkg::EPP_SETUP;
            end
          ppt_pkg::EPP_SETUP:
          begin
            cnt_r <= cnt_r + 1'b1;
            if (!epp.wait_n)
            begin
              epp.dstb_n <= epp.is_addr;
              epp.astb_n <= ~epp.is_addr;
              state_r    <= ppt_pkg::EPP_STROBE;
            end
          end
          ppt_pkg::EPP_STROBE:
          begin
            cnt_r <= cnt_r + 1'b1;
            if (epp.wait_n)
            begin
              epp.rdata   <= epp.pins;
              epp.dstb_n  <= 1'b1;
              epp.astb_n  <= 1'b1;
              epp.write_n <= 1'b1;
              epp.done    <= 1'b1;
              state_r     <= ppt_pkg::EPP_IDLE;
            end
          end
          default:
            state_r <= ppt_pkg::EPP_IDLE;
        endcase
      end
    end
  end

  // watchdog must end every cycle on time
  a_watchdog_abort : assert property (@(posedge clk_sys_in) disable iff (srst_in)
    expired_w |=> epp.done && epp.tmo && !epp.active)
    else $error("epp watchdog did not abort the cycle");
endmodule // ppt_epp

/* File: ppt_periph.sv */
// printer-side peripheral model answering epp handshakes
`timescale 1ns/1ps
module ppt_periph (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  // port side
  input  wire logic [7:0] pins_drv_in,
  input  wire logic       pins_oe_in,
  input  wire logic       dstb_n_in,
  input  wire logic       astb_n_in,
  // bench controls
  input  wire logic [7:0] rdata_in,
  input  wire logic       stall_in,
  input  wire logic       idle_busy_in,
  // peripheral side
  output logic      [7:0] pins_out,
  output logic            wait_out,
  output logic      [7:0] seen_out
);
  logic cyc;
  // a strobe on either channel opens a cycle
  assign cyc = ~dstb_n_in | ~astb_n_in;
  // off-cycle the lines show the inverse, so a stale copy never reads as valid
  assign pins_out = pins_oe_in ? pins_drv_in : (cyc ? rdata_in : ~rdata_in);
  // wait released a cycle after the strobe unless stalled; stalling forces the watchdog
  always_ff @(posedge clk_sys_in)
  begin
    wait_out <= srst_in ? 1'b0 : (cyc ? ~stall_in : idle_busy_in);
    if (cyc && pins_oe_in)
      seen_out <= pins_drv_in;
  end
endmodule // ppt_periph

/* File: ppt_port_tb.sv */
// self-checking bench for the printer port registers and pins
`timescale 1ns/1ps
`include "ppt_map.svh"
module ppt_port_tb;
  logic        clk_sys_in, srst_in = 1'b1, req = 1'b0, we = 1'b0, stall = 1'b0, busy = 1'b0;
  logic        err_n = 1'b1, online = 1'b0, paper = 1'b0, ack_n = 1'b1;
  logic        oe, strb_n, afd_n, init_n, sel_n, irq, ack, pwait;
  logic [7:0]  adr = 8'h00, rdata = 8'hc3, pout, pin, seen, q;
  logic [31:0] wdat = 32'h00000000, rdat;
  int          fails = 0, n_checks = 0, irqs = 0;

  ppt_port i_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .wb_cyc_in(req), .wb_stb_in(req),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .parallel_data_pins_in(pin), .parallel_data_pins_out(pout), .parallel_data_pins_oe_out(oe),
    .printer_error_input_n_in(err_n), .printer_online_input_in(online), .paper_out_input_in(paper),
    .printer_ack_input_n_in(ack_n), .printer_busy_in(pwait), .strobe_out_pin_n_out(strb_n),
    .autofeed_out_pin_n_out(afd_n), .printer_initialise_line_n_out(init_n),
    .select_in_out_pin_n_out(sel_n), .port_irq_out(irq));
  ppt_periph i_periph (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .pins_drv_in(pout), .pins_oe_in(oe),
    .dstb_n_in(afd_n), .astb_n_in(sel_n), .rdata_in(rdata), .stall_in(stall), .idle_busy_in(busy),
    .pins_out(pin), .wait_out(pwait), .seen_out(seen));

  // 25 MHz system clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // interrupt pulses counted one per high cycle
  always @(posedge clk_sys_in)
    if (irq === 1'b1)
      irqs++;

  task automatic chk(input string what, input logic [7:0] seen_v, input logic [7:0] exp_v);
    n_checks++;
    if (seen_v !== exp_v)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // classic wishbone cycle; ack and data taken at the edge that samples ack high
  task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_sys_in);
    req <= 1'b1;
    we <= w;
    adr <= {2'b00, idx, 2'b00};
    wdat <= {24'h000000, d};
    for (n = 0; n < 400 && ack !== 1'b1; n++)
      @(posedge clk_sys_in);
    if (n == 400)
    begin
      fails++;
      stop_test();
    end
    q = rdat[7:0];
    req <= 1'b0;
  endtask

  // stalled epp read runs into the watchdog
  task automatic tmo();
    stall <= 1'b1;
    wb(1'b0, 4'h5, 8'h00);
    chk("tmo_rd", q, 8'h00);
    stall <= 1'b0;
    wb(1'b0, `PPT_IDX_STATUS, 8'h00);
    chk("tmo_set", q & 8'h01, 8'h01);
  endtask

  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    chk("pins_rst", pout, 8'h00);
    chk("pin_rst", {4'h0, strb_n, afd_n, init_n, sel_n}, 8'h0d);
    wb(1'b0, `PPT_IDX_DATA, 8'h00);
    chk("data_rst", q, 8'h00);
    wb(1'b0, `PPT_IDX_CTRL, 8'h00);
    chk("ctrl_rst", q, 8'h00);
    wb(1'b1, `PPT_IDX_DATA, 8'ha5);
    repeat (8) @(posedge clk_sys_in);
    chk("pins_out", pout, 8'ha5);
    wb(1'b0, `PPT_IDX_DATA, 8'h00);
    chk("data_rd", q, 8'ha5);
    wb(1'b1, `PPT_IDX_CTRL, 8'hff);
    wb(1'b0, `PPT_IDX_CTRL, 8'h00);
    chk("ctrl_rd", q, 8'h3f);
    chk("oe", {7'h00, oe}, 8'h01);
    chk("pin_ctl", {4'h0, strb_n, afd_n, init_n, sel_n}, 8'h02);
    // strobe lines back high so the peripheral model lets busy through to the wait line
    wb(1'b1, `PPT_IDX_CTRL, 8'h00);
    // two complementary status patterns, every bit seen both ways
    for (int i = 0; i < 2; i++)
    begin
      {err_n, online, paper, ack_n, busy} <= i ? 5'b10010 : 5'b01101;
      repeat (8) @(posedge clk_sys_in);
      wb(1'b0, `PPT_IDX_STATUS, 8'h00);
      chk("status", q, {~busy, ack_n, paper, online, err_n, 3'b000});
    end
    // one rising ack edge with the enable set, then cleared
    for (int e = 1; e >= 0; e--)
    begin
      wb(1'b1, `PPT_IDX_CTRL, e ? 8'h10 : 8'h00);
      ack_n <= 1'b0;
      repeat (8) @(posedge clk_sys_in);
      irqs = 0;
      ack_n <= 1'b1;
      repeat (10) @(posedge clk_sys_in);
      chk("irq", 8'(irqs), 8'(e));
    end
    for (int a = 3; a < 8; a++)
    begin
      wb(1'b1, 4'(a), 8'h77);
      wb(1'b0, 4'(a), 8'h00);
      chk("off_rd", q, 8'h00);
    end
    wb(1'b1, `PPT_IDX_CFG, 8'h01);
    wb(1'b1, `PPT_IDX_CTRL, 8'h20);
    repeat (8) @(posedge clk_sys_in);
    chk("oe_bidir", {7'h00, oe}, 8'h00);
    wb(1'b0, `PPT_IDX_DATA, 8'h00);
    chk("bidir_rd", q, ~rdata);
    busy <= 1'b0;
    wb(1'b1, `PPT_IDX_CFG, 8'h02);
    wb(1'b1, `PPT_IDX_CTRL, 8'h04);
    wb(1'b1, 4'h4, 8'h3c);
    chk("epp_wr", seen, 8'h3c);
    wb(1'b0, `PPT_IDX_EPP_ADDR, 8'h00);
    chk("epp_rd", q, rdata);
    tmo();
    wb(1'b1, `PPT_IDX_STATUS, 8'h00);
    wb(1'b0, `PPT_IDX_STATUS, 8'h00);
    chk("tmo_w0", q & 8'h01, 8'h01);
    wb(1'b1, `PPT_IDX_STATUS, 8'h01);
    wb(1'b0, `PPT_IDX_STATUS, 8'h00);
    chk("tmo_w1", q & 8'h01, 8'h00);
    wb(1'b1, `PPT_IDX_CFG, 8'h12);
    tmo();
    wb(1'b0, `PPT_IDX_STATUS, 8'h00);
    chk("tmo_rdclr", q & 8'h01, 8'h00);
    stop_test();
  end
endmodule // ppt_port_tb
